// file: hdl/utec_tx_endpoint.sv
// USB transmit endpoint control and status logic behind a classic Wishbone slave
`timescale 1ns/1ps
module utec_tx_endpoint
	import utec_pkg::*;
(
	input wire logic clk_i, // 100 MHz controller clock
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic host_role_i, // Controller currently in host role
	input wire logic shared_fifo_i, // Endpoint FIFO shared by both directions
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [31:0] wb_adr_i, // Wishbone byte address
	input wire logic [3:0] wb_sel_i, // Wishbone byte selects
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire utec_pkg::utec_link_ev_t ev_i, // Link events, one-cycle pulses
	output utec_pkg::utec_link_out_t link_o // Endpoint controls toward link
);
	import utec_pkg::*;

	logic [15:0] csr;
	logic [15:0] next_csr;
	logic [1:0] attempts;
	logic [1:0] next_attempts;
	logic ack;
	logic next_ack;
	logic [31:0] rdat;
	logic [31:0] next_rdat;
	utec_link_out_t lo;
	utec_link_out_t next_lo;

	logic hit;
	logic wr;
	logic [15:0] wd;
	logic [15:0] wen;
	logic [15:0] view;

	assign hit = (wb_adr_i == CSR_ADDR);
	assign wen = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wd = wb_dat_i[15:0] & wen;
	// Write lands on the edge where the master samples ack
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack && hit;
	// Both layouts view one storage word
	assign view = csr & (host_role_i ? HOST_RD_MASK : DEV_RD_MASK); // R17 R18 R23

	always_comb
	begin
		next_ack = wb_cyc_i && wb_stb_i && !ack;
		next_rdat = 32'h0000_0000;
		if (next_ack && hit)
		begin
			next_rdat = {16'h0000, view};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack <= 1'b0;
			rdat <= 32'h0000_0000;
		end
		else
		begin
			ack <= next_ack;
			rdat <= next_rdat;
		end
	end

	always_comb
	begin
		logic stall_on;
		logic drop;
		logic sent;
		stall_on = 1'b0;
		drop = 1'b0;
		sent = 1'b0;
		next_csr = csr;
		next_attempts = attempts;
		next_lo = lo;
		next_lo.stall_hs = 1'b0;
		next_lo.flush = 1'b0;
		next_lo.tx_irq = 1'b0;
		next_lo.err_irq = 1'b0;

		// Software writes first, so hardware events below win over clears
		if (wr)
		begin
			next_csr[B_MODE] = wd[B_MODE];
			next_csr[B_DMA_EN] = wd[B_DMA_EN];
			next_csr[B_DPOL] = wd[B_DPOL];
			if (!host_role_i)
			begin
				next_csr[B_ISO] = wd[B_ISO];
				next_csr[B_B4] = wd[B_B4];
			end
			else
			begin
				next_csr[B_ISO] = 1'b0;
				if (wd[B_UNLOCK] || csr[B_UNLOCK])
				begin
					next_csr[B_TOG] = wd[B_TOG]; // R21
					next_csr[B_UNLOCK] = 1'b0; // R21
				end
				if (!wd[B_NAK])
				begin
					next_csr[B_NAK] = 1'b0;
				end
				if (wd[B_B4] && wd[B_LOAD])
				begin
					next_csr[B_B4] = 1'b1; // R22
					next_csr[B_TOG] = 1'b0; // R22
				end
			end
			if (wd[B_FLIP])
			begin
				next_csr[B_TOG] = !csr[B_TOG]; // R04
				next_lo.flush = 1'b1; // R04
				next_csr[B_LOAD] = 1'b0; // R04
			end
			if (wd[B_TRST])
			begin
				next_csr[B_TOG] = 1'b0; // R06
			end
			if (wd[B_FLUSH] && csr[B_LOAD])
			begin
				next_lo.flush = 1'b1; // R10 R11
				next_csr[B_LOAD] = 1'b0; // R10
			end
			// Sticky flags clear on a written zero, keep on a one
			if (!wd[B_STALLF])
			begin
				next_csr[B_STALLF] = 1'b0;
			end
			if (!wd[B_ERR])
			begin
				next_csr[B_ERR] = 1'b0;
			end
			if (!wd[B_OCC])
			begin
				next_csr[B_OCC] = 1'b0;
			end
			if (wd[B_LOAD] && !wd[B_FLIP])
			begin
				next_csr[B_LOAD] = 1'b1; // R15
			end
		end

		if (!host_role_i)
		begin
			// Isochronous endpoints never stall
			stall_on = csr[B_B4] && !csr[B_ISO]; // R08 R09
			if (ev_i.in_token)
			begin
				if (stall_on)
				begin
					next_lo.stall_hs = 1'b1; // R08
					next_csr[B_STALLF] = 1'b1; // R07
					drop = 1'b1; // R07
				end
				else if (!csr[B_LOAD])
				begin
					next_csr[B_ERR] = 1'b1; // R13
					next_lo.err_irq = 1'b1;
				end
			end
		end
		else
		begin
			if (ev_i.stall_rx)
			begin
				next_csr[B_STALLF] = 1'b1; // R20
				drop = 1'b1; // R20
			end
			if (ev_i.nak_timeout)
			begin
				next_csr[B_NAK] = 1'b1;
			end
			if (ev_i.no_handshake && !csr[B_ISO])
			begin
				if (attempts == ATTEMPT_LIMIT - 2'h1)
				begin
					next_attempts = 2'h0;
					next_csr[B_ERR] = 1'b1; // R19
					next_lo.err_irq = 1'b1; // R19
				end
				else
				begin
					next_attempts = attempts + 2'h1;
				end
			end
		end

		if (ev_i.pkt_sent && csr[B_LOAD] && !drop)
		begin
			sent = 1'b1;
			next_csr[B_LOAD] = 1'b0; // R15
			next_csr[B_TOG] = !csr[B_TOG];
			next_attempts = 2'h0;
			if (host_role_i)
			begin
				next_csr[B_B4] = 1'b0;
			end
			// DMA policy set hides per-packet interrupts
			next_lo.tx_irq = !(csr[B_DMA_EN] && csr[B_DPOL]); // R05 R16
		end
		if (drop)
		begin
			next_lo.flush = 1'b1; // R07 R20
			next_csr[B_LOAD] = 1'b0; // R07 R20
		end
		if (ev_i.fifo_has_pkt)
		begin
			next_csr[B_OCC] = 1'b1; // R14
		end

		next_lo.dir_tx = shared_fifo_i ? next_csr[B_MODE] : 1'b1; // R02
		// Ask for data only while the endpoint has no packet waiting
		next_lo.dma_req = next_csr[B_DMA_EN] && next_lo.dir_tx && !next_csr[B_LOAD] && !sent; // R03
		next_lo.toggle = next_csr[B_TOG];
		next_lo.setup_tok = host_role_i && next_csr[B_B4] && next_csr[B_LOAD]; // R22
		next_lo.iso = !host_role_i && next_csr[B_ISO]; // R01
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			csr <= CSR_RESET;
			attempts <= 2'h0;
			lo <= '0;
		end
		else
		begin
			csr <= next_csr;
			attempts <= next_attempts;
			lo <= next_lo;
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = rdat;
	assign link_o = lo;
endmodule : utec_tx_endpoint

// file: shared/utec_pkg.sv
// Package for the USB transmit endpoint control block: offsets, fields, state carriers
// Overview of operation
// R01 - Bit 14 set selects isochronous; clear selects bulk or interrupt transfers.
// R02 - Bit 13 picks Tx or Rx direction, only when the FIFO is shared.
// R03 - Bit 12 set lets the endpoint raise DMA requests for transmit data.
// R04 - Writing one to bit 11 flips the toggle and drops the current packet.
// R05 - With DMA, bit 10 set keeps only error interrupts; clear interrupts per packet.
// R06 - Writing one to bit 6 resets the data toggle to zero.
// R07 - Sending STALL sets bit 5, flushes FIFO, clears packet-loaded; software clears it.
// R08 - While bit 4 is set every IN token gets a STALL handshake.
// R09 - The stall request does nothing while the endpoint is isochronous.
// R10 - Writing one to bit 3 flushes next packet and clears packet-loaded.
// R11 - A flush is ignored unless packet-loaded is set.
// R12 - Software may flush twice to empty a double-buffered FIFO; here the second flush is ignored, as packet-loaded is already clear.
// R13 - An IN token with packet-loaded clear sets sticky underrun bit 2.
// R14 - Bit 1 is set whenever the FIFO holds a packet; software clears it.
// R15 - Software sets bit 0 after loading a packet; hardware clears it when sent.
// R16 - Clearing packet-loaded after transmission raises the transmit interrupt if enabled.
// R17 - In device role bits 15 and 9 to 7 read as zero.
// R18 - Host role layout: bits 13-10 control, 9 unlock, 8 toggle, 7 NAK halt, 6 reset.
// R19 - Host role: three attempts with no handshake set error and interrupt, non-iso only.
// R20 - Host role: a received STALL sets its flag, flushes, clears packet-loaded.
// R21 - Toggle bit takes writes only while unlock is set; unlock then self-clears.
// R22 - Host role: setup select with packet-loaded sends SETUP and clears the toggle.
// R23 - The register shows device or host layout by current role, one storage.
package utec_pkg;
	localparam logic [31:0] CSR_ADDR = 32'h0000_0000;
	localparam int B_ISO = 14;
	localparam int B_MODE = 13;
	localparam int B_DMA_EN = 12;
	localparam int B_FLIP = 11;
	localparam int B_DPOL = 10;
	localparam int B_UNLOCK = 9;
	localparam int B_TOG = 8;
	localparam int B_NAK = 7;
	localparam int B_TRST = 6;
	localparam int B_STALLF = 5;
	localparam int B_B4 = 4;
	localparam int B_FLUSH = 3;
	localparam int B_ERR = 2;
	localparam int B_OCC = 1;
	localparam int B_LOAD = 0;
	localparam logic [1:0] ATTEMPT_LIMIT = 2'h3;
	localparam logic [15:0] CSR_RESET = 16'h0000;
	localparam logic [15:0] DEV_RD_MASK = 16'h7c7f;
	localparam logic [15:0] HOST_RD_MASK = 16'h3fff;

	typedef struct packed {
		logic in_token;
		logic pkt_sent;
		logic stall_rx;
		logic no_handshake;
		logic nak_timeout;
		logic fifo_has_pkt;
	} utec_link_ev_t;

	typedef struct packed {
		logic stall_hs;
		logic flush;
		logic tx_irq;
		logic err_irq;
		logic dma_req;
		logic toggle;
		logic setup_tok;
		logic iso;
		logic dir_tx;
	} utec_link_out_t;
endpackage : utec_pkg

// file: tb/utec_checker.sv
// Port checker for the transmit endpoint
`timescale 1ns/1ps
module utec_checker
	import utec_pkg::*;
(
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic host_role_i, // Role
	input wire logic shared_fifo_i, // Shared FIFO
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic [31:0] wb_dat_o, // Read data
	input wire logic wb_ack_o, // Acknowledge
	input wire utec_pkg::utec_link_ev_t ev_i, // Events
	input wire utec_pkg::utec_link_out_t link_o // Controls
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack timing wrong");
	reserved_zero_a: assert property (wb_ack_o && !$past(host_role_i) |-> wb_dat_o[15] == 1'b0 && wb_dat_o[9:7] == 3'h0)
		else $error("reserved bits set");
	dir_fixed_a: assert property (!$past(shared_fifo_i) && !$past(rst_i) |-> link_o.dir_tx)
		else $error("direction not transmit");
	stall_flush_a: assert property (link_o.stall_hs |-> link_o.flush && !$past(link_o.iso))
		else $error("stall without flush");
	stall_cause_a: assert property (link_o.stall_hs |-> $past(ev_i.in_token) && !$past(host_role_i))
		else $error("stall without token");
	irq_cause_a: assert property (link_o.tx_irq |-> $past(ev_i.pkt_sent))
		else $error("irq without send");
	dma_dir_a: assert property (link_o.dma_req |-> link_o.dir_tx)
		else $error("dma request while receiving");
	err_cause_a: assert property (link_o.err_irq |-> $past(ev_i.in_token) || $past(ev_i.no_handshake))
		else $error("error irq without cause");
	iso_role_a: assert property (link_o.iso |-> !$past(host_role_i))
		else $error("iso in host role");
	setup_role_a: assert property (link_o.setup_tok |-> $past(host_role_i))
		else $error("setup in device role");
	cover property (link_o.stall_hs);
	cover property (link_o.tx_irq);
	cover property (link_o.flush && !link_o.stall_hs);
endmodule : utec_checker
bind utec_tx_endpoint utec_checker i_utec_checker (.clk_i(clk_i), .rst_i(rst_i), .host_role_i(host_role_i),
	.shared_fifo_i(shared_fifo_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .ev_i(ev_i), .link_o(link_o));

// file: tb/utec_link_model.sv
// Bus partner model: issues tokens, handshakes data packets
`timescale 1ns/1ps
module utec_link_model
	import utec_pkg::*;
(
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire utec_pkg::utec_link_ev_t req_i, // Bench requests
	input wire logic ack_en_i, // Handshake data
	input wire utec_pkg::utec_link_out_t link_i, // Controls
	output utec_pkg::utec_link_ev_t ev_o // Events
);
	logic pend;
	utec_link_ev_t next_ev;
	// No handshake after a STALL or an underrun, as a real host would not see data
	always_comb
	begin
		next_ev = req_i;
		if (pend && ack_en_i && !link_i.stall_hs && !link_i.err_irq)
		begin
			next_ev.pkt_sent = 1'b1;
		end
	end
	always_ff @(posedge clk_i)
	begin
		pend <= ev_o.in_token && !rst_i;
		ev_o <= rst_i ? '0 : next_ev;
	end
endmodule : utec_link_model

// file: tb/utec_tx_endpoint_control_tb_top.sv
// Self-checking bench for the transmit endpoint
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
	$display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module usb_tx_endpoint_control_tb_top;
	import utec_pkg::*;
	logic clk_i = 0, rst_i = 1, host = 0, shr = 1, cyc = 0, stb = 0, we = 0, ack, ack_en = 1;
	logic [31:0] adr = 0, dat = 0, dat_o, seed = 32'hcd61;
	logic [3:0] sel = 4'hf;
	logic [15:0] rd, v;
	utec_link_ev_t req = '0, ev;
	utec_link_out_t lo;
	int err_total, samples_checked, n_irq, n_fl, n_st;
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		n_irq += lo.tx_irq;
		n_fl += lo.flush;
		n_st += lo.stall_hs;
	end
	utec_tx_endpoint i_utec_tx_endpoint (.clk_i(clk_i), .rst_i(rst_i), .host_role_i(host), .shared_fifo_i(shr),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .ev_i(ev), .link_o(lo));
	utec_link_model i_utec_link_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .ack_en_i(ack_en),
		.link_i(lo), .ev_o(ev));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [15:0] exp_rd(input logic [15:0] w, input logic h);
		return w & (h ? HOST_RD_MASK : DEV_RD_MASK);
	endfunction : exp_rd
	task report_and_stop;
		$display("compared %0d mismatched %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	task bus(input logic w, input logic [15:0] d);
		int n;
		n = 0;
		cyc <= 1;
		stb <= 1;
		we <= w;
		dat <= {16'h0000, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1)
		begin
			err_total++;
			report_and_stop();
		end
		rd = dat_o[15:0];
		cyc <= 0;
		stb <= 0;
		@(posedge clk_i);
	endtask : bus
	task link(input utec_link_ev_t e);
		req <= e;
		@(posedge clk_i);
		req <= '0;
		repeat (5) @(posedge clk_i);
	endtask : link
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		bus(0, 0);
		`CHK(rd, CSR_RESET)
		for (int i = 0; i < 6; i++)
		begin
			seed = lfsr(seed);
			v = seed[15:0] & 16'h7400;
			shr <= seed[16];
			bus(1, v);
			bus(0, 0);
			`CHK(rd, exp_rd(v, 0))
			`CHK(lo.iso, v[14])
			`CHK(lo.dir_tx, seed[16] ? v[13] : 1'b1)
			`CHK(lo.dma_req, v[12] & (seed[16] ? v[13] : 1'b1))
		end
		bus(1, 16'hffff);
		bus(0, 0);
		`CHK(rd, 16'h7410)
		bus(1, 16'h0040);
		`CHK(lo.toggle, 1'b0)
		bus(1, 16'h0001);
		link(6'h20);
		bus(0, 0);
		`CHK({rd, lo.toggle, n_irq}, {16'h0000, 1'b1, 32'd1})
		bus(1, 16'h0800);
		`CHK(lo.toggle, 1'b0)
		link(6'h20);
		bus(0, 0);
		`CHK(rd, 16'h0004)
		bus(1, 16'h0011);
		link(6'h20);
		bus(0, 0);
		`CHK({rd, n_st}, {16'h0030, 32'd1})
		bus(1, 16'h4011);
		link(6'h20);
		bus(0, 0);
		`CHK({rd, n_st}, {16'h4010, 32'd1})
		bus(1, 16'h1401);
		link(6'h20);
		`CHK({n_irq, lo.toggle}, {32'd2, 1'b0})
		bus(1, 16'h0001);
		v = n_fl[15:0];
		bus(1, 16'h0008);
		bus(1, 16'h0008);
		bus(0, 0);
		`CHK({rd, n_fl[15:0]}, {16'h0000, v + 16'h0001})
		link(6'h01);
		adr <= 32'h4;
		bus(1, 16'h0000);
		bus(0, 0);
		`CHK(rd, 16'h0000)
		adr <= 0;
		bus(0, 0);
		`CHK(rd, 16'h0002)
		host <= 1;
		bus(1, 16'h0100);
		`CHK(lo.toggle, 1'b0)
		bus(1, 16'h0300);
		bus(0, 0);
		`CHK({rd, lo.toggle}, {16'h0100, 1'b1})
		bus(1, 16'h0011);
		`CHK({lo.setup_tok, lo.toggle}, {1'b1, 1'b0})
		link(6'h08);
		bus(0, 0);
		`CHK({rd, lo.setup_tok}, {16'h0030, 1'b0})
		link(6'h04);
		link(6'h04);
		bus(0, 0);
		`CHK(rd, 16'h0030)
		link(6'h04);
		bus(0, 0);
		`CHK(rd, 16'h0034)
		bus(1, 16'h0300);
		bus(1, 16'h0040);
		`CHK(lo.toggle, 1'b0)
		$display("tests done");
		report_and_stop();
	end
endmodule : usb_tx_endpoint_control_tb_top
